// [shared/exec_pkg.sv]
// Constants and types shared by the jump and set-bit execution logic.
// Assumes one core clock with every instruction cycle split into four quarters.
package exec_pkg;

    localparam int          PC_W           = 21;
    localparam int          OFF_W          = 11;
    localparam int          FADDR_W        = 12;
    localparam logic [20:0] PC_RESET       = 21'h000000;
    localparam logic [20:0] PC_STEP        = 21'h000002;
    localparam logic [3:0]  OPC_JUMP       = 4'hd;
    localparam logic [3:0]  OPC_SETBIT     = 4'h8;
    localparam int          OPC_POS        = 12;
    localparam int          BIT_POS        = 9;
    localparam int          MODE_POS       = 8;
    localparam logic [7:0]  IDX_LIMIT      = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
    localparam logic [7:0]  BIT_ONE        = 8'h01;
    localparam int          QUARTERS       = 4;

    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b11,
        Q4 = 2'b10
    } quarter_e;

    typedef enum logic [1:0] {
        OP_NONE   = 2'h0,
        OP_JUMP   = 2'h1,
        OP_SETBIT = 2'h2
    } op_e;

    typedef struct packed {
        logic [11:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
        logic        indexed;
    } file_req_s;

endpackage

// [hw/branch_and_bit_set_exec.sv]
// Execution logic for the relative jump and the set-bit file register instruction.
// Assumes the fetch logic presents the instruction word in quarter Q1 and the file
// register memory returns read data combinationally in the quarter that reads.
// Operation
// RULE1 - A relative jump loads the program counter with the jump address plus 2 plus twice the offset.
// RULE2 - The jump offset is a two's complement word count from -1024 through 1023.
// RULE3 - A relative jump is decoded from top opcode bits 1101 with an eleven-bit offset below.
// RULE4 - A relative jump is one word and two cycles, the second cycle doing nothing.
// RULE5 - The set-bit instruction forces the chosen bit 0 to 7 to one and keeps the others.
// RULE6 - The set-bit instruction has top nibble 1000, then bit index, bank-mode flag and file address.
// RULE7 - With the bank-mode flag at zero the quick-access bank is used whatever the bank pointer holds.
// RULE8 - With the bank-mode flag at one the bank comes from the bank select pointer.
// RULE9 - With the extended set on and the flag at zero, addresses up to 95 use indexed literal offset.
// RULE10 - The set-bit instruction reads in Q2, modifies in Q3 and writes in Q4 without touching flags.
`timescale 1ns/1ps

module branch_and_bit_set_exec
    import exec_pkg::*;
(
    input  wire logic               sys_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic [15:0]        instr_in,
    input  wire logic [3:0]         bank_select_pointer_in,
    input  wire logic               ext_set_en_in,
    input  wire logic [FADDR_W-1:0] index_base_in,
    input  wire logic [7:0]         file_rdata_in,
    output logic [PC_W-1:0]         pc_out,
    output file_req_s               file_req_out,
    output logic                    nop_cycle_out,
    output quarter_e                quarter_out
);

    quarter_e          q_reg;
    quarter_e          q_next;
    op_e               op_reg;
    op_e               op_next;
    logic [15:0]       ir_reg;
    logic [15:0]       ir_next;
    logic [PC_W-1:0]   pc_reg;
    logic [PC_W-1:0]   pc_next;
    logic [PC_W-1:0]   off_reg;
    logic [PC_W-1:0]   off_next;
    logic [PC_W-1:0]   target_reg;
    logic [PC_W-1:0]   target_next;
    logic [7:0]        rd_data_reg;
    logic [7:0]        rd_data_next;
    logic              flush_reg;
    logic              flush_next;
    file_req_s         req_reg;
    file_req_s         req_next;
    logic [7:0]        f_addr;
    logic [2:0]        bit_sel;
    logic              mode_bit;

    assign f_addr   = instr_in[7:0];
    assign bit_sel  = ir_reg[BIT_POS+2:BIT_POS];
    assign mode_bit = instr_in[MODE_POS];

    always_comb begin
        q_next       = q_reg;
        op_next      = op_reg;
        ir_next      = ir_reg;
        pc_next      = pc_reg;
        off_next     = off_reg;
        target_next  = target_reg;
        rd_data_next = rd_data_reg;
        flush_next   = flush_reg;
        req_next     = req_reg;
        unique case (q_reg)
            Q1: begin
                q_next  = Q2;
                op_next = OP_NONE;
                if (!flush_reg) begin
                    ir_next = instr_in;
                    // RULE3 jump opcode decode.
                    if (instr_in[15:OPC_POS] == OPC_JUMP) begin
                        op_next = OP_JUMP;
                    end
                    // RULE6 set-bit opcode decode.
                    if (instr_in[15:OPC_POS] == OPC_SETBIT) begin
                        op_next            = OP_SETBIT;
                        req_next.rd        = 1'b1;
                        req_next.indexed   = 1'b0;
                        if (mode_bit) begin
                            // RULE8 banked by pointer.
                            req_next.addr = {bank_select_pointer_in, f_addr};
                        end else if (ext_set_en_in && f_addr <= IDX_LIMIT) begin
                            // RULE9 indexed literal offset.
                            req_next.addr    = index_base_in + {4'h0, f_addr};
                            req_next.indexed = 1'b1;
                        end else if (f_addr < ACCESS_SPLIT) begin
                            // RULE7 quick-access bank low.
                            req_next.addr = {ACCESS_LO_BANK, f_addr};
                        end else begin
                            req_next.addr = {ACCESS_HI_BANK, f_addr};
                        end
                    end
                end
            end
            Q2: begin
                q_next      = Q3;
                req_next.rd = 1'b0;
                if (op_reg == OP_JUMP) begin
                    // RULE2 sign extend offset.
                    off_next = {{(PC_W-OFF_W){ir_reg[OFF_W-1]}}, ir_reg[OFF_W-1:0]};
                end
                if (op_reg == OP_SETBIT) begin
                    // RULE10 read in Q2.
                    rd_data_next = file_rdata_in;
                end
            end
            Q3: begin
                q_next = Q4;
                if (op_reg == OP_JUMP) begin
                    // RULE1 target computation.
                    target_next = pc_reg + PC_STEP + {off_reg[PC_W-2:0], 1'b0};
                end
                if (op_reg == OP_SETBIT) begin
                    // RULE5 set chosen bit.
                    req_next.wdata = rd_data_reg | (BIT_ONE << bit_sel);
                    req_next.wr    = 1'b1;
                end
            end
            Q4: begin
                q_next      = Q1;
                req_next.wr = 1'b0;
                // RULE4 second cycle idle.
                flush_next  = (op_reg == OP_JUMP);
                if (op_reg == OP_JUMP) begin
                    pc_next = target_reg;
                end else if (!flush_reg) begin
                    pc_next = pc_reg + PC_STEP;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q_reg       <= Q1;
            op_reg      <= OP_NONE;
            ir_reg      <= 16'h0000;
            pc_reg      <= PC_RESET;
            off_reg     <= '0;
            target_reg  <= '0;
            rd_data_reg <= 8'h00;
            flush_reg   <= 1'b0;
            req_reg     <= '0;
        end else begin
            q_reg       <= q_next;
            op_reg      <= op_next;
            ir_reg      <= ir_next;
            pc_reg      <= pc_next;
            off_reg     <= off_next;
            target_reg  <= target_next;
            rd_data_reg <= rd_data_next;
            flush_reg   <= flush_next;
            req_reg     <= req_next;
        end
    end

    assign pc_out        = pc_reg;
    assign file_req_out  = req_reg;
    assign nop_cycle_out = flush_reg;
    assign quarter_out   = q_reg;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_jump_target;
        logic [PC_W-1:0] pc_v;
        logic [10:0]     n_v;
        (q_reg == Q1 && !flush_reg && instr_in[15:OPC_POS] == OPC_JUMP, pc_v = pc_reg, n_v = instr_in[10:0])
        |-> ##4 pc_reg == pc_v + PC_STEP + {{(PC_W-OFF_W-1){n_v[10]}}, n_v, 1'b0};
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target wrong"); // RULE1

    property p_offset_range;
        (q_reg == Q3 && op_reg == OP_JUMP)
        |-> (off_reg[PC_W-1:OFF_W-1] == '0) || (&off_reg[PC_W-1:OFF_W-1]);
    endproperty
    a_offset_range: assert property (p_offset_range) else $error("offset not sign extended"); // RULE2

    property p_jump_decode;
        (q_reg == Q1 && !flush_reg && instr_in[15:OPC_POS] == OPC_JUMP) |=> op_reg == OP_JUMP;
    endproperty
    a_jump_decode: assert property (p_jump_decode) else $error("jump not decoded"); // RULE3

    property p_jump_idle;
        (q_reg == Q4 && op_reg == OP_JUMP)
        |=> (flush_reg && !file_req_out.rd && !file_req_out.wr)[*4] ##1 !flush_reg;
    endproperty
    a_jump_idle: assert property (p_jump_idle) else $error("second jump cycle not idle"); // RULE4

    property p_set_bit;
        $rose(file_req_out.wr)
        |-> file_req_out.wdata == (rd_data_reg | (BIT_ONE << bit_sel)) && file_req_out.wdata[bit_sel];
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("set-bit data wrong"); // RULE5

    property p_setbit_decode;
        (q_reg == Q1 && !flush_reg && instr_in[15:OPC_POS] == OPC_SETBIT)
        |=> file_req_out.rd && op_reg == OP_SETBIT;
    endproperty
    a_setbit_decode: assert property (p_setbit_decode) else $error("set-bit not decoded"); // RULE6

    property p_access_bank;
        (q_reg == Q1 && !flush_reg && instr_in[15:OPC_POS] == OPC_SETBIT && !mode_bit && !ext_set_en_in)
        |=> file_req_out.addr[11:8] == (($past(f_addr) < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK);
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("quick-access bank not used"); // RULE7

    property p_bank_ptr;
        (q_reg == Q1 && !flush_reg && instr_in[15:OPC_POS] == OPC_SETBIT && mode_bit)
        |=> file_req_out.addr == {$past(bank_select_pointer_in), $past(f_addr)} && !file_req_out.indexed;
    endproperty
    a_bank_ptr: assert property (p_bank_ptr) else $error("bank pointer not used"); // RULE8

    property p_indexed;
        (q_reg == Q1 && !flush_reg && instr_in[15:OPC_POS] == OPC_SETBIT && !mode_bit)
        |=> file_req_out.indexed == ($past(ext_set_en_in) && $past(f_addr) <= IDX_LIMIT);
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed mode choice wrong"); // RULE9

    property p_rmw_timing;
        $rose(file_req_out.rd) |-> q_reg == Q2 ##1 !file_req_out.rd ##1 file_req_out.wr ##1 !file_req_out.wr;
    endproperty
    a_rmw_timing: assert property (p_rmw_timing) else $error("read-modify-write timing wrong"); // RULE10

    c_jump:       cover property (q_reg == Q4 && op_reg == OP_JUMP);
    c_jump_back:  cover property (q_reg == Q3 && op_reg == OP_JUMP && off_reg[PC_W-1]);
    c_set_banked: cover property (file_req_out.wr && !file_req_out.indexed);
    c_set_index:  cover property (file_req_out.wr && file_req_out.indexed);

endmodule

// [tb/tb_branch_and_bit_set_exec.sv]
// Self-checking bench for the relative jump and set-bit execution logic.
// Assumes the design takes a word at the end of each Q1 except the one after a jump and answers per the hand-over timing.
`timescale 1ns/1ps

module tb_branch_and_bit_set_exec
    import exec_pkg::*;
;
    logic              sys_clk_in;
    logic              rst_n_in;
    logic [15:0]       instr_in;
    logic [3:0]        bank_select_pointer_in;
    logic              ext_set_en_in;
    logic [11:0]       index_base_in;
    logic [7:0]        file_rdata_in;
    logic [PC_W-1:0]   pc_out;
    file_req_s         file_req_out;
    logic              nop_cycle_out;
    quarter_e          quarter_out;
    logic [PC_W-1:0]   exp_pc;
    logic [31:0]       seed;
    int                bad_count;
    int                n_tests;

    branch_and_bit_set_exec u_branch_and_bit_set_exec (
        .sys_clk_in             (sys_clk_in),
        .rst_n_in               (rst_n_in),
        .instr_in               (instr_in),
        .bank_select_pointer_in (bank_select_pointer_in),
        .ext_set_en_in          (ext_set_en_in),
        .index_base_in          (index_base_in),
        .file_rdata_in          (file_rdata_in),
        .pc_out                 (pc_out),
        .file_req_out           (file_req_out),
        .nop_cycle_out          (nop_cycle_out),
        .quarter_out            (quarter_out)
    );

    always #5 sys_clk_in = ~sys_clk_in;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Expected {indexed, address} of a set-bit word.
    function automatic logic [12:0] exp_addr(input logic [15:0] w, input logic [3:0] bp, input logic ext,
                                             input logic [11:0] base);
        if (w[MODE_POS])
            return {1'b0, bp, w[7:0]};
        if (ext && w[7:0] <= IDX_LIMIT)
            return {1'b1, base + {4'h0, w[7:0]}};
        return {1'b0, (w[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, w[7:0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Runs one word from the edge that opens its Q1 to the edge that opens the next taken Q1.
    task automatic exec(input logic [15:0] w, input logic [3:0] bp, input logic ext, input logic [11:0] base,
                        input logic [7:0] rd);
        logic is_set;
        logic is_jmp;
        is_set = (w[15:12] == OPC_SETBIT);
        is_jmp = (w[15:12] == OPC_JUMP);
        instr_in <= w;
        bank_select_pointer_in <= bp;
        ext_set_en_in <= ext;
        index_base_in <= base;
        file_rdata_in <= rd;
        @(negedge sys_clk_in);
        chk(pc_out, exp_pc);
        chk(quarter_out, Q1);
        chk(nop_cycle_out, 1'b0);
        @(posedge sys_clk_in);
        instr_in <= ~w;
        @(negedge sys_clk_in);
        chk(file_req_out.rd, is_set);
        if (is_set) chk({file_req_out.indexed, file_req_out.addr}, exp_addr(w, bp, ext, base));
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk(file_req_out.wr, is_set);
        if (is_set) chk(file_req_out.wdata, rd | (BIT_ONE << w[11:9]));
        @(posedge sys_clk_in);
        exp_pc = exp_pc + PC_STEP;
        if (is_jmp) begin
            instr_in <= {OPC_SETBIT, 12'hfff};
            exp_pc = exp_pc + {{9{w[10]}}, w[10:0], 1'b0};
            @(negedge sys_clk_in);
            chk(pc_out, exp_pc);
            chk(nop_cycle_out, 1'b1);
            @(negedge sys_clk_in);
            chk(file_req_out.rd, 1'b0);
            repeat (2) @(posedge sys_clk_in);
            @(negedge sys_clk_in);
            chk(nop_cycle_out, 1'b1);
            @(posedge sys_clk_in);
        end
    endtask

    task automatic summarize();
        $display("counts: checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #50000;
        bad_count++;
        summarize();
    end

    initial begin
        logic [31:0] r;
        sys_clk_in = 1'b0;
        rst_n_in = 1'b0;
        instr_in = 16'h0000;
        bank_select_pointer_in = 4'h0;
        ext_set_en_in = 1'b0;
        index_base_in = 12'h000;
        file_rdata_in = 8'h00;
        seed = 32'h46ab7595;
        bad_count = 0;
        n_tests = 0;
        exp_pc = PC_RESET;
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        exec(16'h8f0a, 4'h3, 1'b0, 12'h000, 8'h0a);
        exec(16'h8010, 4'h5, 1'b0, 12'h000, 8'hfe);
        exec(16'h807f, 4'h5, 1'b1, 12'h123, 8'h00);
        exec(16'h8080, 4'h5, 1'b1, 12'h123, 8'h7f);
        exec(16'h805f, 4'h5, 1'b1, 12'hff0, 8'h80);
        exec(16'h8060, 4'h5, 1'b1, 12'hff0, 8'h55);
        exec(16'h8d00, 4'h9, 1'b1, 12'h100, 8'h00);
        $display("test set_bit_corners done");
        exec(16'hd3ff, 4'h0, 1'b0, 12'h000, 8'h00);
        exec(16'hd400, 4'h0, 1'b0, 12'h000, 8'h00);
        exec(16'hd7ff, 4'h0, 1'b0, 12'h000, 8'h00);
        exec(16'hd000, 4'h0, 1'b0, 12'h000, 8'h00);
        exec(16'h0000, 4'h0, 1'b0, 12'h000, 8'h00);
        exec(16'he3ff, 4'h0, 1'b0, 12'h000, 8'h00);
        $display("test jump_corners done");
        repeat (60) begin
            r = rnd();
            exec({r[31] ? OPC_JUMP : OPC_SETBIT, r[11:0]}, r[15:12], r[16], r[27:16], r[24:17]);
        end
        $display("test random_mix done");
        @(negedge sys_clk_in);
        chk(pc_out, exp_pc);
        summarize();
    end
endmodule
